// *** core/ttcs_pkg.sv ***
package ttcs_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] TTCS_TIMING_OFS  = 8'h00;
    localparam logic [7:0] TTCS_EGRESS_OFS  = 8'h04;
    localparam logic [7:0] TTCS_STATUS_OFS  = 8'h08;

    // Field positions in the timing options register.
    localparam int TTCS_HSBP_BIT     = 7;
    localparam int TTCS_OCSEL_BIT    = 4;
    localparam int TTCS_PLL_REFERENCE_SELECT_LSB   = 2;
    localparam int TTCS_REFDIV_BIT   = 1;
    localparam int TTCS_OVERRIDE_BIT = 0;

    // Field positions in the egress configuration register.
    localparam int TTCS_MODE_LSB     = 0;
    localparam int TTCS_TWO_MEG_BIT  = 2;
    localparam int TTCS_BYPASS_BIT   = 3;

    // Values after reset.
    localparam logic [7:0] TTCS_TIMING_RST = 8'h04;
    localparam logic [3:0] TTCS_EGRESS_RST = 4'h3;

    // Division ratios and gapping counts, in sampled source edges, and the pin synchronizer depth.
    localparam int TTCS_CT_DIV      = 8;
    localparam int TTCS_XM_DIV      = 24;
    localparam int TTCS_HS_DIV_SET  = 2;
    localparam int TTCS_HS_DIV_CLR  = 3;
    localparam int TTCS_GAP_FRAME   = 32;
    localparam int TTCS_GAP_FILLER  = 8;
    localparam int TTCS_SYNC_STAGES = 3;

    typedef struct packed {
        logic       hsbp;
        logic       ocsel;
        logic [1:0] pll_reference_select;
        logic       refdiv;
        logic       override;
    } ttcs_timing_t;

    typedef struct packed {
        logic       fifo_bypass;
        logic       two_meg;
        logic [1:0] mode;
    } ttcs_egress_t;

    typedef enum logic [1:0] {
        TTCS_SM_JA = 2'h0,
        TTCS_SM_CT = 2'h1,
        TTCS_SM_XM = 2'h2
    } ttcs_smooth_t;

    typedef enum logic [1:0] {
        TTCS_LN_PLL    = 2'h0,
        TTCS_LN_FIFO   = 2'h1,
        TTCS_LN_EGRESS = 2'h2
    } ttcs_line_t;

    typedef enum logic [1:0] {
        TTCS_REF_GAPPED = 2'h0,
        TTCS_REF_EGRESS = 2'h1,
        TTCS_REF_RX     = 2'h2,
        TTCS_REF_CT     = 2'h3
    } ttcs_ref_t;

endpackage

// *** core/ttcs_clk_mux.sv ***
`timescale 1ns/1ps
module ttcs_clk_mux
    import ttcs_pkg::*;
#(
    parameter int N = 4,
    parameter int W = 2
) (
    // Clock and reset.
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Sources and selection.
    input  wire logic [N-1:0] src,
    input  wire logic [W-1:0] sel,
    // Selected clock.
    output logic              out_ff
);

    logic [W-1:0] cur_ff;
    logic [W-1:0] nxt_cur;
    logic         nxt_out;
    wire          pending  = (sel != cur_ff);
    wire          src_cur  = src[cur_ff];
    wire          src_new  = src[sel];

    // A pending switch lets the current high phase finish, parks low, and
    // moves over only while the new source is low, so no period is cut.
    assign nxt_cur = (pending && !out_ff && !src_new) ? sel : cur_ff;
    assign nxt_out = pending ? (out_ff && src_cur) : src_cur;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff <= '0;
            out_ff <= 1'b0;
        end else begin
            cur_ff <= nxt_cur;
            out_ff <= nxt_out;
        end
    end

    a_mux_no_runt: assert property (@(posedge pclk) disable iff (!presetn)
        (pending && out_ff) |=> cur_ff == $past(cur_ff))
        else $error("clock mux switched during a high phase");

    a_mux_rise_src: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(out_ff) |-> $past(src_cur) && !$past(pending))
        else $error("clock mux output rose without its source");

endmodule

// *** core/ttcs_timing_select.sv ***
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module ttcs_timing_select
    import ttcs_pkg::*;
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata_ff,
    output logic             pready_ff,
    output logic             pslverr_ff,
    // Clock pins.
    input  wire logic        ja_smooth_clock,
    input  wire logic        common_transmit_clock,
    input  wire logic        master_clock_in,
    input  wire logic        egress_clock_in,
    input  wire logic        receive_line_clock,
    input  wire logic        ja_pll_clock,
    // Derived clocks.
    output logic             smooth_clock_ff,
    output logic             fifo_output_clock_ff,
    output logic             pll_reference_ff,
    output logic             transmit_line_clock_ff,
    output logic             high_speed_clock_ff,
    output logic             gapped_egress_clock_ff
);

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling.

    localparam int NPIN = 6;
    localparam int P_JA = 0;
    localparam int P_CT = 1;
    localparam int P_XM = 2;
    localparam int P_EG = 3;
    localparam int P_RX = 4;
    localparam int P_PL = 5;

    wire  [NPIN-1:0] pin_raw = {ja_pll_clock, receive_line_clock,
                                egress_clock_in, master_clock_in,
                                common_transmit_clock, ja_smooth_clock};
    logic [NPIN-1:0] filt_ff;
    logic [NPIN-1:0] filt_d_ff;
    wire  [NPIN-1:0] rise = filt_ff & ~filt_d_ff;
    wire  [NPIN-1:0] fall = ~filt_ff & filt_d_ff;

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_sync
            logic [TTCS_SYNC_STAGES-1:0] s_ff;
            // A level counts only once the second and third stage agree.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s_ff         <= '0;
                    filt_ff[g]   <= 1'b0;
                    filt_d_ff[g] <= 1'b0;
                end else begin
                    s_ff <= {s_ff[TTCS_SYNC_STAGES-2:0], pin_raw[g]};
                    if (s_ff[1] == s_ff[2])
                        filt_ff[g] <= s_ff[2];
                    filt_d_ff[g] <= filt_ff[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    ttcs_timing_t timing_ff;
    ttcs_egress_t egress_ff;

    wire acc       = psel && penable && !pready_ff;
    wire hit_tim   = (paddr == TTCS_TIMING_OFS);
    wire hit_egr   = (paddr == TTCS_EGRESS_OFS);
    wire hit_sta   = (paddr == TTCS_STATUS_OFS);
    wire mapped    = hit_tim || hit_egr || hit_sta;
    // A write lands at the edge where the master sees pready_ff high, while
    // it still holds address and data.
    wire done      = psel && penable && pready_ff;
    wire wr_tim    = done && pwrite && hit_tim;
    wire wr_egr    = done && pwrite && hit_egr;

    ttcs_smooth_t smooth_sel;
    ttcs_line_t   line_sel;
    ttcs_ref_t    ref_sel;

    wire [31:0] rd_tim = {24'h0, timing_ff.hsbp, 2'h0, timing_ff.ocsel,
                          timing_ff.pll_reference_select, timing_ff.refdiv,
                          timing_ff.override};
    wire [31:0] rd_egr = {28'h0, egress_ff};
    wire [31:0] rd_sta = {26'h0, ref_sel, line_sel, smooth_sel};
    wire [31:0] nxt_rdata = (!acc || pwrite) ? 32'h0 :
                            hit_tim ? rd_tim :
                            hit_egr ? rd_egr :
                            hit_sta ? rd_sta : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timing_ff  <= ttcs_timing_t'({TTCS_TIMING_RST[7],
                                          TTCS_TIMING_RST[4:0]});
            egress_ff  <= ttcs_egress_t'(TTCS_EGRESS_RST);
            prdata_ff  <= 32'h0;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            if (wr_tim)
                timing_ff <= {pwdata[TTCS_HSBP_BIT], pwdata[TTCS_OCSEL_BIT],
                              pwdata[TTCS_PLL_REFERENCE_SELECT_LSB+:2],
                              pwdata[TTCS_REFDIV_BIT],
                              pwdata[TTCS_OVERRIDE_BIT]};
            if (wr_egr)
                egress_ff <= {pwdata[TTCS_BYPASS_BIT],
                              pwdata[TTCS_TWO_MEG_BIT],
                              pwdata[TTCS_MODE_LSB+:2]};
            prdata_ff  <= nxt_rdata;
            pready_ff  <= acc;
            pslverr_ff <= acc && !mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dividers and gapping.

    logic [3:0] ct_cnt_ff;
    logic [3:0] xm_cnt_ff;
    logic [1:0] hs_cnt_ff;
    logic [4:0] gap_cnt_ff;
    logic       ct_div_ff;
    logic       xm_div_ff;

    localparam logic [3:0] CT_HALF = 4'(TTCS_CT_DIV / 2 - 1);
    localparam logic [3:0] XM_HALF = 4'(TTCS_XM_DIV / 2 - 1);
    localparam logic [1:0] HS_SET  = 2'(TTCS_HS_DIV_SET - 1);
    localparam logic [1:0] HS_CLR  = 2'(TTCS_HS_DIV_CLR - 1);
    localparam logic [4:0] GAP_END = 5'(TTCS_GAP_FRAME - 1);
    localparam logic [4:0] GAP_FIL = 5'(TTCS_GAP_FILLER);

    wire [1:0] hs_top  = timing_ff.hsbp ? HS_SET : HS_CLR;
    wire       ct_wrap = (ct_cnt_ff == CT_HALF);
    wire       xm_wrap = (xm_cnt_ff == XM_HALF);
    wire       hs_wrap = (hs_cnt_ff >= hs_top);
    // The first byte time of each 32-bit group is filler and is gapped out.
    // The count steps on falling edges, so it holds through a high phase and
    // a gapped high phase is never cut short.
    wire       gap_open = (gap_cnt_ff >= GAP_FIL) || !egress_ff.two_meg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ct_cnt_ff  <= 4'h0;
            xm_cnt_ff  <= 4'h0;
            hs_cnt_ff  <= 2'h0;
            gap_cnt_ff <= 5'h0;
            ct_div_ff  <= 1'b0;
            xm_div_ff  <= 1'b0;
        end else begin
            if (rise[P_CT]) begin
                ct_cnt_ff <= ct_wrap ? 4'h0 : ct_cnt_ff + 4'h1;
                ct_div_ff <= ct_div_ff ^ ct_wrap;
            end
            if (rise[P_XM]) begin
                xm_cnt_ff <= xm_wrap ? 4'h0 : xm_cnt_ff + 4'h1;
                xm_div_ff <= xm_div_ff ^ xm_wrap;
                hs_cnt_ff <= hs_wrap ? 2'h0 : hs_cnt_ff + 2'h1;
            end
            if (fall[P_EG])
                gap_cnt_ff <= (gap_cnt_ff == GAP_END) ? 5'h0 :
                              gap_cnt_ff + 5'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_speed_clock_ff    <= 1'b0;
            gapped_egress_clock_ff <= 1'b0;
        end else begin
            high_speed_clock_ff    <= (hs_cnt_ff == 2'h0);
            gapped_egress_clock_ff <= filt_ff[P_EG] && gap_open;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source selection.

    wire slave_mode = egress_ff.mode[1];
    // The unsupported divider-set, override-clear code falls back to the
    // attenuator clock rather than an undefined source.
    assign smooth_sel = !timing_ff.override ? TTCS_SM_JA :
                        timing_ff.refdiv    ? TTCS_SM_XM :
                                              TTCS_SM_CT;
    assign ref_sel = (timing_ff.pll_reference_select == 2'h0 && egress_ff.two_meg) ?
                         TTCS_REF_GAPPED :
                     (timing_ff.pll_reference_select[1] == 1'b0) ? TTCS_REF_EGRESS :
                     ttcs_ref_t'(timing_ff.pll_reference_select);
    wire pll_unused = timing_ff.ocsel || timing_ff.override;
    wire bypass     = slave_mode && egress_ff.fifo_bypass &&
                      !egress_ff.two_meg;
    assign line_sel = bypass     ? TTCS_LN_EGRESS :
                      pll_unused ? TTCS_LN_FIFO :
                                   TTCS_LN_PLL;

    wire [3:0] sm_src  = {1'b0, xm_div_ff, ct_div_ff, filt_ff[P_JA]};
    wire [1:0] fo_src  = {filt_ff[P_CT], smooth_clock_ff};
    wire [3:0] ref_src = {filt_ff[P_CT], filt_ff[P_RX], filt_ff[P_EG],
                          gapped_egress_clock_ff};
    wire [3:0] ln_src  = {1'b0, filt_ff[P_EG], fifo_output_clock_ff,
                          filt_ff[P_PL]};

    ttcs_clk_mux #(.N(4), .W(2)) u_smooth (
        .pclk    (pclk),
        .presetn (presetn),
        .src     (sm_src),
        .sel     (smooth_sel),
        .out_ff  (smooth_clock_ff)
    );

    ttcs_clk_mux #(.N(2), .W(1)) u_fifo_out (
        .pclk    (pclk),
        .presetn (presetn),
        .src     (fo_src),
        .sel     (timing_ff.ocsel),
        .out_ff  (fifo_output_clock_ff)
    );

    ttcs_clk_mux #(.N(4), .W(2)) u_pll_ref (
        .pclk    (pclk),
        .presetn (presetn),
        .src     (ref_src),
        .sel     (ref_sel),
        .out_ff  (pll_reference_ff)
    );

    ttcs_clk_mux #(.N(4), .W(2)) u_line (
        .pclk    (pclk),
        .presetn (presetn),
        .src     (ln_src),
        .sel     (line_sel),
        .out_ff  (transmit_line_clock_ff)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    a_smooth_ja: assert property (@(posedge pclk) disable iff (!presetn)
        (!timing_ff.refdiv && !timing_ff.override) |-> smooth_sel == TTCS_SM_JA)
        else $error("smooth clock not from attenuator");

    a_smooth_ct_div: assert property (@(posedge pclk) disable iff (!presetn)
        rise[P_CT] && ct_cnt_ff == CT_HALF |=> ct_div_ff != $past(ct_div_ff))
        else $error("common clock divider missed its toggle");

    a_smooth_xm_sel: assert property (@(posedge pclk) disable iff (!presetn)
        (timing_ff.refdiv && timing_ff.override) |-> smooth_sel == TTCS_SM_XM)
        else $error("smooth clock not from master divider");

    a_line_pll_mode: assert property (@(posedge pclk) disable iff (!presetn)
        (slave_mode && !egress_ff.fifo_bypass && !pll_unused)
        |-> line_sel == TTCS_LN_PLL)
        else $error("line clock not from attenuator PLL");

    a_ref_egress: assert property (@(posedge pclk) disable iff (!presetn)
        (!egress_ff.two_meg) |-> (ref_sel == (timing_ff.pll_reference_select[1] ?
            ttcs_ref_t'(timing_ff.pll_reference_select) : TTCS_REF_EGRESS)))
        else $error("PLL reference selection wrong");

    sequence s_fill_byte;
        egress_ff.two_meg && gap_cnt_ff < GAP_FIL;
    endsequence
    a_gap_filler: assert property (@(posedge pclk) disable iff (!presetn)
        s_fill_byte ##0 $stable(gap_cnt_ff) |=> !gapped_egress_clock_ff)
        else $error("gapped clock ran during filler byte");

    a_line_unused: assert property (@(posedge pclk) disable iff (!presetn)
        (!bypass && pll_unused) |-> line_sel == TTCS_LN_FIFO)
        else $error("line clock not from FIFO output clock");

    a_line_bypass: assert property (@(posedge pclk) disable iff (!presetn)
        bypass |-> line_sel == TTCS_LN_EGRESS)
        else $error("bypass did not select egress clock");

    a_hs_period: assert property (@(posedge pclk) disable iff (!presetn)
        rise[P_XM] && hs_cnt_ff == hs_top |=> hs_cnt_ff == 2'h0)
        else $error("high-speed divider ratio wrong");

    sequence s_apb_access;
        psel && penable && !pready_ff;
    endsequence
    a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        s_apb_access |=> pready_ff ##1 !pready_ff)
        else $error("APB answer not one cycle after access");

endmodule

// *** testbench/ttcs_pin_model.sv ***
`timescale 1ns/1ps
module ttcs_pin_model #(
    parameter int JA_H = 6,
    parameter int CT_H = 5,
    parameter int XM_H = 4,
    parameter int EG_H = 7,
    parameter int RX_H = 9,
    parameter int PL_H = 11
) (
    // Sampling clock.
    input  wire logic pclk,
    // Clock pins toward the block.
    output logic      ja_smooth_clock,
    output logic      common_transmit_clock,
    output logic      master_clock_in,
    output logic      egress_clock_in,
    output logic      receive_line_clock,
    output logic      ja_pll_clock
);
    ////////////////////////////////////////////////////////////////////////
    // Line clocks run free; they are timed off pclk so that every period
    // seen at the outputs is an exact whole number of pclk cycles.
    localparam int H [6] = '{JA_H, CT_H, XM_H, EG_H, RX_H, PL_H};
    logic [5:0] pins = 6'h00;
    int         cnt [6] = '{0, 0, 0, 0, 0, 0};

    always_ff @(posedge pclk) begin
        for (int i = 0; i < 6; i++) begin
            if (cnt[i] == H[i] - 1) begin
                cnt[i]  <= 0;
                pins[i] <= ~pins[i];
            end else begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign ja_smooth_clock       = pins[0];
    assign common_transmit_clock = pins[1];
    assign master_clock_in       = pins[2];
    assign egress_clock_in       = pins[3];
    assign receive_line_clock    = pins[4];
    assign ja_pll_clock          = pins[5];
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import ttcs_pkg::*;
    localparam int JA_H = 6;
    localparam int CT_H = 5;
    localparam int XM_H = 4;
    localparam int EG_H = 7;
    localparam int RX_H = 9;
    localparam int PL_H = 11;
    logic        pclk;
    logic        presetn;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [5:0]  pin;
    logic [5:0]  outs;
    int          miscompares = 0;
    int          checks_done = 0;
    int          min_hi = 1000;
    int          hi_len = 0;
    int          seed;
    logic [15:0] cfgq [$];

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    ttcs_pin_model #(.JA_H(JA_H), .CT_H(CT_H), .XM_H(XM_H), .EG_H(EG_H),
        .RX_H(RX_H), .PL_H(PL_H)) ttcs_pin_model_inst (
        .pclk(pclk), .ja_smooth_clock(pin[0]),
        .common_transmit_clock(pin[1]), .master_clock_in(pin[2]),
        .egress_clock_in(pin[3]), .receive_line_clock(pin[4]),
        .ja_pll_clock(pin[5]));

    ttcs_timing_select ttcs_timing_select_inst (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata_ff(prdata_ff), .pready_ff(pready_ff),
        .pslverr_ff(pslverr_ff), .ja_smooth_clock(pin[0]),
        .common_transmit_clock(pin[1]), .master_clock_in(pin[2]),
        .egress_clock_in(pin[3]), .receive_line_clock(pin[4]),
        .ja_pll_clock(pin[5]), .smooth_clock_ff(outs[0]),
        .fifo_output_clock_ff(outs[1]), .pll_reference_ff(outs[2]),
        .transmit_line_clock_ff(outs[3]), .high_speed_clock_ff(outs[4]),
        .gapped_egress_clock_ff(outs[5]));

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready_ff !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk("apb answer", 1, 0);
            final_report;
        end
        rd = prdata_ff;
        er = pslverr_ff;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Rise-to-rise distance of one output, in pclk cycles.
    task automatic period(input int i, output int p);
        int   n;
        bit   st;
        logic prv;
        p = 0;
        st = 0;
        n = 0;
        prv = outs[i];
        for (int k = 0; k < 1000; k++) begin
            @(posedge pclk);
            if (outs[i] === 1'b1 && prv === 1'b0) begin
                if (st) begin
                    p = n;
                    break;
                end
                st = 1;
                n = 0;
            end
            prv = outs[i];
            n++;
        end
    endtask

    task automatic rises(input int i, input int len, output int c);
        logic prv;
        c = 0;
        prv = outs[i];
        repeat (len) begin
            @(posedge pclk);
            if (outs[i] === 1'b1 && prv === 1'b0)
                c++;
            prv = outs[i];
        end
    endtask

    task automatic run_cfg(input logic [15:0] cf);
        logic [7:0]  t;
        logic [3:0]  e;
        logic [31:0] rd;
        logic        er;
        logic [1:0]  sm, ln, rs;
        int          ep0, ep1, ep2, ep3, ep4, p, c, g;
        t = cf[15:8];
        e = cf[3:0];
        apb(1'b1, TTCS_TIMING_OFS, {24'h0, t}, rd, er);
        apb(1'b1, TTCS_EGRESS_OFS, {28'h0, e}, rd, er);
        apb(1'b0, TTCS_TIMING_OFS, 32'h0, rd, er);
        chk("timing reg", {24'h0, t & 8'h9f}, rd);
        apb(1'b0, TTCS_EGRESS_OFS, 32'h0, rd, er);
        chk("egress reg", {28'h0, e}, rd);
        sm = t[0] ? (t[1] ? 2'h2 : 2'h1) : 2'h0;
        ln = (e[1] && e[3] && !e[2]) ? 2'h2 : ((t[4] || t[0]) ? 2'h1 : 2'h0);
        rs = (t[3:2] == 2'h0) ? (e[2] ? 2'h0 : 2'h1) : t[3:2];
        ep0 = sm == 0 ? 2 * JA_H : (sm == 1 ? 2 * CT_H * TTCS_CT_DIV
                                            : 2 * XM_H * TTCS_XM_DIV);
        ep1 = t[4] ? 2 * CT_H : ep0;
        ep3 = ln == 2 ? 2 * EG_H : (ln == 1 ? ep1 : 2 * PL_H);
        ep2 = rs == 1 ? 2 * EG_H : (rs == 2 ? 2 * RX_H : 2 * CT_H);
        ep4 = 2 * XM_H * (t[7] ? TTCS_HS_DIV_SET : TTCS_HS_DIV_CLR);
        repeat (500) @(posedge pclk);
        apb(1'b0, TTCS_STATUS_OFS, 32'h0, rd, er);
        chk("status", {26'h0, rs, ln, sm}, rd);
        period(0, p);
        chk("smooth period", ep0, p);
        period(1, p);
        chk("fifo out period", ep1, p);
        period(3, p);
        chk("line period", ep3, p);
        period(4, p);
        chk("high speed period", ep4, p);
        if (rs != 2'h0) begin
            period(2, p);
            chk("reference period", ep2, p);
        end else begin
            g = 64 * (TTCS_GAP_FRAME - TTCS_GAP_FILLER) / TTCS_GAP_FRAME;
            rises(5, 128 * EG_H, c);
            chk("gapped egress edges", g, c);
            rises(2, 128 * EG_H, c);
            chk("gapped reference edges", g, c);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // A cut high phase on the line clock shows as a short high run.
    always @(posedge pclk) begin
        if (outs[3] === 1'b1) begin
            hi_len++;
        end else begin
            if (hi_len > 0 && hi_len < min_hi)
                min_hi = hi_len;
            hi_len = 0;
        end
    end

    initial begin
        repeat (95000) @(posedge pclk);
        chk("run time", 1, 0);
        final_report;
    end

    initial begin
        logic [31:0] rd, r;
        logic        er;
        logic [7:0]  t;
        logic [3:0]  e;
        int          n;
        seed = 32'hb05bcf89;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, TTCS_TIMING_OFS, 32'h0, rd, er);
        chk("timing reset", {24'h0, TTCS_TIMING_RST}, rd);
        apb(1'b0, TTCS_EGRESS_OFS, 32'h0, rd, er);
        chk("egress reset", {28'h0, TTCS_EGRESS_RST}, rd);
        apb(1'b1, 8'h0c, 32'hffffffff, rd, er);
        chk("unmapped write error", 1, er);
        apb(1'b0, 8'h0c, 32'h0, rd, er);
        chk("unmapped read data", 0, rd);
        $display("test registers done");
        cfgq = '{16'h0403, 16'h0402, 16'h0803, 16'h0c03, 16'h8102,
                 16'h0303, 16'h1003, 16'h8006, 16'h000a, 16'h8002};
        repeat (4) begin
            r = $random(seed);
            t = r[7:0] & 8'h9f;
            e = r[11:8];
            if (t[1])
                t[0] = 1'b1;
            if (!e[1])
                e[2] = 1'b0;
            if (e[2])
                t = {1'b1, 2'h0, 1'b0, t[3:2], 2'h0};
            cfgq.push_back({t, 4'h0, e});
        end
        n = 0;
        while (cfgq.size() > 0) begin
            run_cfg(cfgq.pop_front());
            $display("test config %0d done", n);
            n++;
        end
        chk("line high phase kept", 1, min_hi >= CT_H);
        final_report;
    end
endmodule
